// ==== dcv_pkg.sv ====
// Purpose: shared constants and carrier types of the dual chained vectored irq unit
// Assumes: APB slave with 12-bit byte addresses and 32-bit data
// Notes:   register offsets are byte addresses, one aligned word each
package dcv_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int DCV_CH          = 32;
    localparam int DCV_UNIT_CH     = 16;
    localparam int DCV_IDX_W       = 4;
    localparam int DCV_SRC_W       = 5;
    localparam int DCV_WAKE_N      = 32;
    localparam int DCV_EXT_WAKE_N  = 30;
    localparam int DCV_PERIPH_N    = 27;
    localparam int DCV_WAKE_AUX_N  = 4;
    // source slot of the wakeup_or_channel, aux wake requests follow it
    localparam int DCV_WAKE_OR_SRC = 25;
    localparam int DCV_WAKE_AUX_LO = 26;
    localparam int DCV_HI_PERIPH   = DCV_CH - DCV_WAKE_AUX_LO - DCV_WAKE_AUX_N;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] DCV_OFF_RAW    = 12'h000;
    localparam logic [11:0] DCV_OFF_ENA    = 12'h004;
    localparam logic [11:0] DCV_OFF_FORCE  = 12'h008;
    localparam logic [11:0] DCV_OFF_FAST   = 12'h00C;
    localparam logic [11:0] DCV_OFF_VECT   = 12'h010;
    localparam logic [11:0] DCV_OFF_SRCID  = 12'h014;
    localparam logic [11:0] DCV_OFF_REQST  = 12'h018;
    localparam logic [11:0] DCV_OFF_DEFV   = 12'h01C;
    localparam logic [11:0] DCV_OFF_WSTAT  = 12'h020;
    localparam logic [11:0] DCV_OFF_WMASK  = 12'h024;
    localparam logic [3:0]  DCV_PAGE_VADDR = 4'h1;
    localparam logic [3:0]  DCV_PAGE_VMAP  = 4'h2;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [31:0] DCV_RST_WORD  = 32'h0000_0000;
    localparam int          DCV_REQST_NRM = 0;
    localparam int          DCV_REQST_FST = 1;
    localparam int          DCV_SRCID_VLD = 5;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dcv_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } dcv_apb_rsp_type;

    typedef struct packed {
        logic                 valid;
        logic [DCV_SRC_W-1:0] src;
        logic [31:0]          vaddr;
    } dcv_win_type;

    typedef enum logic {
        DCV_CFG_VADDR,
        DCV_CFG_MAP
    } dcv_cfg_type;

endpackage

// ==== dcv_pin_sync.sv ====
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to ref_clk
// Notes:   output moves only when the second and third stage agree
`timescale 1ns/1ps
module dcv_pin_sync
    import dcv_pkg::*;
#(
    parameter int W = DCV_WAKE_N
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    // pins and filtered level
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;
    logic [W-1:0] lvl_d;

    if (W < 1) begin : g_chk
        $error("dcv_pin_sync: W must be at least 1");
    end

    // s1 feeds s2 only; the filter looks at s2 and s3
    always_comb begin
        lvl_d = (s3_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end else begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;

endmodule

// ==== dcv_vec_unit.sv ====
// Purpose: one vectored_irq_unit of sixteen prioritised channels with daisy-chain input
// Assumes: sources already in the ref_clk domain
// Notes:   own winner beats anything arriving on the chain input
`timescale 1ns/1ps
module dcv_vec_unit
    import dcv_pkg::*;
#(
    parameter int          CH        = DCV_UNIT_CH,
    parameter logic [4:0]  UNIT_BASE = 5'h00
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 arst_n,
    // sources and per-source / per-channel controls
    input  wire logic [CH-1:0]        src_req,
    input  wire logic [CH-1:0]        src_en,
    input  wire logic [CH-1:0]        src_fast,
    input  wire logic [CH-1:0]        chan_force,
    // configuration access
    input  wire logic                 cfg_we,
    input  wire dcv_cfg_type          cfg_sel,
    input  wire logic [DCV_IDX_W-1:0] cfg_idx,
    input  wire logic [31:0]          cfg_wdata,
    output logic      [31:0]          rd_vaddr,
    output logic      [DCV_IDX_W-1:0] rd_map,
    // daisy chain
    input  wire dcv_win_type          chain_in,
    output dcv_win_type               chain_out,
    // request summary
    output logic      [CH-1:0]        chan_req,
    output logic                      fast_any
);

    logic [31:0]          vaddr_q [CH];
    logic [31:0]          vaddr_d [CH];
    logic [DCV_IDX_W-1:0] map_q   [CH];
    logic [DCV_IDX_W-1:0] map_d   [CH];
    logic                 own_vld;
    logic [DCV_IDX_W-1:0] own_ch;

    if (CH != (1 << DCV_IDX_W)) begin : g_chk
        $error("dcv_vec_unit: CH must equal 2**DCV_IDX_W");
    end

    // ------------------------------------------------------------
    // channel requests
    // ------------------------------------------------------------
    for (genvar c = 0; c < CH; c++) begin : g_ch
        assign chan_req[c] = (src_req[map_q[c]] & src_en[map_q[c]] & ~src_fast[map_q[c]])
                           | chan_force[c];
    end

    assign fast_any = |(src_req & src_en & src_fast);

    // ------------------------------------------------------------
    // priority and chain
    // ------------------------------------------------------------
    always_comb begin
        own_vld = 1'b0;
        own_ch  = '0;
        for (int c = CH - 1; c >= 0; c--) begin
            if (chan_req[c]) begin
                own_vld = 1'b1;
                own_ch  = DCV_IDX_W'(c);
            end
        end
        if (own_vld) begin
            chain_out.valid = 1'b1;
            chain_out.src   = UNIT_BASE + {1'b0, map_q[own_ch]};
            chain_out.vaddr = vaddr_q[own_ch];
        end else begin
            chain_out = chain_in;
        end
    end

    // ------------------------------------------------------------
    // configuration storage
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < CH; c++) begin
            vaddr_d[c] = vaddr_q[c];
            map_d[c]   = map_q[c];
        end
        if (cfg_we && cfg_sel == DCV_CFG_VADDR) begin
            vaddr_d[cfg_idx] = cfg_wdata;
        end
        if (cfg_we && cfg_sel == DCV_CFG_MAP) begin
            map_d[cfg_idx] = cfg_wdata[DCV_IDX_W-1:0];
        end
    end

    // identity mapping after reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int c = 0; c < CH; c++) begin
                vaddr_q[c] <= DCV_RST_WORD;
                map_q[c]   <= DCV_IDX_W'(c);
            end
        end else begin
            for (int c = 0; c < CH; c++) begin
                vaddr_q[c] <= vaddr_d[c];
                map_q[c]   <= map_d[c];
            end
        end
    end

    assign rd_vaddr = vaddr_q[cfg_idx];
    assign rd_map   = map_q[cfg_idx];

endmodule

// ==== dcv_irq_top.sv ====
// Purpose: combined interrupt controller of two chained vectored units with wake-up collector
// Assumes: APB master per the usual protocol; peripheral requests are on ref_clk
// Notes:   zero-wait APB slave, read data captured in the setup cycle
//
// Contract
// - two identical vectored units chained as primary and secondary
// - 32 prioritised channels, fast and normal outputs, fast ranks higher
// - fast request carries no source or vector
// - any of the 32 sources can be routed to fast
// - normal request is the OR of all vectored channel requests
// - channel 0 highest priority, channel 31 lowest
// - software maps sources onto channels within one unit
// - every primary request beats every secondary request
// - winner resolved; handler reads source identity and vector address
// - vector fetched in one single bus access
// - software can force any vectored channel
// - five wake-unit channels, twenty-seven peripheral channels
// - one channel is the OR of all 32 wake inputs
// - wake inputs are thirty external lines, rtc and bus resume
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
module dcv_irq_top
    import dcv_pkg::*;
(
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      arst_n,
    // apb slave
    input  wire dcv_apb_req_type           apb_req,
    output dcv_apb_rsp_type                apb_rsp,
    // on-chip request sources
    input  wire logic [DCV_PERIPH_N-1:0]   periph_req,
    input  wire logic [DCV_WAKE_AUX_N-1:0] wake_aux_req,
    // wake-up pins
    input  wire logic [DCV_EXT_WAKE_N-1:0] ext_wake_line,
    input  wire logic                      rtc_irq,
    input  wire logic                      usb_resume,
    // processor requests
    output logic                           fast_cpu_request,
    output logic                           normal_cpu_request,
    output logic                           wake_irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [DCV_WAKE_N-1:0]  wake_pins;
    logic [DCV_WAKE_N-1:0]  wake_lvl;
    logic [DCV_CH-1:0]      src_all;
    logic                   wakeup_or_channel;
    logic [DCV_CH-1:0]      chan_req;
    logic                   fast_p;
    logic                   fast_s;
    dcv_win_type            win_s;
    dcv_win_type            win;
    logic [31:0]            rd_vaddr_p;
    logic [31:0]            rd_vaddr_s;
    logic [DCV_IDX_W-1:0]   rd_map_p;
    logic [DCV_IDX_W-1:0]   rd_map_s;

    logic                   setup;
    logic                   access;
    logic                   page_vaddr;
    logic                   page_vmap;
    logic                   tbl_hit;
    logic [DCV_SRC_W-1:0]   tbl_idx;
    logic                   addr_ok;
    logic [31:0]            rd_word;
    logic                   wr_acc;
    logic                   cfg_we_p;
    logic                   cfg_we_s;
    dcv_cfg_type            cfg_sel;

    logic [31:0] ena_q,   ena_d;
    logic [31:0] force_q, force_d;
    logic [31:0] fast_q,  fast_d;
    logic [31:0] defv_q,  defv_d;
    logic [31:0] wstat_q, wstat_d;
    logic [31:0] wmask_q, wmask_d;
    logic [31:0] prdata_q, prdata_d;
    logic        fastreq_q, fastreq_d;
    logic        normreq_q, normreq_d;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the source slots below assume two full units and this wake set
    if (DCV_CH != 2 * DCV_UNIT_CH) begin : g_chk_units
        $error("dcv_irq_top: DCV_CH must cover exactly two units");
    end
    if (DCV_WAKE_N != DCV_EXT_WAKE_N + 2) begin : g_chk_wake
        $error("dcv_irq_top: wake set is the external lines plus rtc and resume");
    end

    // ------------------------------------------------------------
    // wake-up collector
    // ------------------------------------------------------------
    // wake input set
    assign wake_pins = {usb_resume, rtc_irq, ext_wake_line};

    dcv_pin_sync #(
        .W (DCV_WAKE_N)
    ) u_wake_sync (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .pin_in    (wake_pins),
        .level_out (wake_lvl)
    );

    assign wakeup_or_channel = |(wstat_q & wmask_q);
    // masked sticky status doubles as the cpu wake signal
    assign wake_irq          = wakeup_or_channel;

    // ------------------------------------------------------------
    // source assembly
    // ------------------------------------------------------------
    // five wake, 27 peripheral
    always_comb begin
        src_all = '0;
        src_all[DCV_WAKE_OR_SRC-1:0] = periph_req[DCV_WAKE_OR_SRC-1:0];
        src_all[DCV_WAKE_OR_SRC] = wakeup_or_channel;
        src_all[DCV_WAKE_AUX_LO +: DCV_WAKE_AUX_N] = wake_aux_req;
        src_all[DCV_CH-1 -: DCV_HI_PERIPH] = periph_req[DCV_PERIPH_N-1 -: DCV_HI_PERIPH];
    end

    // ------------------------------------------------------------
    // the two chained units
    // ------------------------------------------------------------
    // secondary feeds primary chain
    dcv_vec_unit #(
        .CH        (DCV_UNIT_CH),
        .UNIT_BASE (DCV_SRC_W'(DCV_UNIT_CH))
    ) u_secondary_irq_unit (
        .ref_clk    (ref_clk),
        .arst_n     (arst_n),
        .src_req    (src_all[DCV_CH-1:DCV_UNIT_CH]),
        .src_en     (ena_q[DCV_CH-1:DCV_UNIT_CH]),
        .src_fast   (fast_q[DCV_CH-1:DCV_UNIT_CH]),
        .chan_force (force_q[DCV_CH-1:DCV_UNIT_CH]),
        .cfg_we     (cfg_we_s),
        .cfg_sel    (cfg_sel),
        .cfg_idx    (tbl_idx[DCV_IDX_W-1:0]),
        .cfg_wdata  (apb_req.pwdata),
        .rd_vaddr   (rd_vaddr_s),
        .rd_map     (rd_map_s),
        .chain_in   ('0),
        .chain_out  (win_s),
        .chan_req   (chan_req[DCV_CH-1:DCV_UNIT_CH]),
        .fast_any   (fast_s)
    );

    dcv_vec_unit #(
        .CH        (DCV_UNIT_CH),
        .UNIT_BASE (5'h00)
    ) u_primary_irq_unit (
        .ref_clk    (ref_clk),
        .arst_n     (arst_n),
        .src_req    (src_all[DCV_UNIT_CH-1:0]),
        .src_en     (ena_q[DCV_UNIT_CH-1:0]),
        .src_fast   (fast_q[DCV_UNIT_CH-1:0]),
        .chan_force (force_q[DCV_UNIT_CH-1:0]),
        .cfg_we     (cfg_we_p),
        .cfg_sel    (cfg_sel),
        .cfg_idx    (tbl_idx[DCV_IDX_W-1:0]),
        .cfg_wdata  (apb_req.pwdata),
        .rd_vaddr   (rd_vaddr_p),
        .rd_map     (rd_map_p),
        .chain_in   (win_s),
        .chain_out  (win),
        .chan_req   (chan_req[DCV_UNIT_CH-1:0]),
        .fast_any   (fast_p)
    );

    // ------------------------------------------------------------
    // processor requests
    // ------------------------------------------------------------
    always_comb begin
        normreq_d = |chan_req;
        fastreq_d = fast_p | fast_s;
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign setup      = apb_req.psel & ~apb_req.penable;
    assign access     = apb_req.psel & apb_req.penable;
    assign page_vaddr = apb_req.paddr[11:8] == DCV_PAGE_VADDR;
    assign page_vmap  = apb_req.paddr[11:8] == DCV_PAGE_VMAP;
    assign tbl_idx    = apb_req.paddr[6:2];
    assign tbl_hit    = (page_vaddr | page_vmap) & ~apb_req.paddr[7]
                      & (apb_req.paddr[1:0] == 2'b00);
    assign cfg_sel    = page_vmap ? DCV_CFG_MAP : DCV_CFG_VADDR;

    always_comb begin
        addr_ok = 1'b1;
        rd_word = DCV_RST_WORD;
        case (apb_req.paddr)
            DCV_OFF_RAW:   rd_word = src_all;
            DCV_OFF_ENA:   rd_word = ena_q;
            DCV_OFF_FORCE: rd_word = force_q;
            DCV_OFF_FAST:  rd_word = fast_q;
            DCV_OFF_VECT:  rd_word = win.valid ? win.vaddr : defv_q;
            DCV_OFF_SRCID: begin
                rd_word[DCV_SRCID_VLD]   = win.valid;
                rd_word[DCV_SRC_W-1:0]   = win.src;
            end
            DCV_OFF_REQST: begin
                rd_word[DCV_REQST_NRM] = normreq_q;
                rd_word[DCV_REQST_FST] = fastreq_q;
            end
            DCV_OFF_DEFV:  rd_word = defv_q;
            DCV_OFF_WSTAT: rd_word = wstat_q;
            DCV_OFF_WMASK: rd_word = wmask_q;
            default: begin
                addr_ok = tbl_hit;
                if (tbl_hit && page_vaddr) begin
                    rd_word = tbl_idx[DCV_IDX_W] ? rd_vaddr_s : rd_vaddr_p;
                end else if (tbl_hit) begin
                    rd_word[DCV_IDX_W-1:0] = tbl_idx[DCV_IDX_W] ? rd_map_s : rd_map_p;
                end
            end
        endcase
    end

    // zero-wait slave: writes land on the access edge
    assign wr_acc   = access & apb_req.pwrite & addr_ok;
    assign cfg_we_p = wr_acc & tbl_hit & ~tbl_idx[DCV_IDX_W];
    assign cfg_we_s = wr_acc & tbl_hit & tbl_idx[DCV_IDX_W];

    // ------------------------------------------------------------
    // register next state
    // ------------------------------------------------------------
    always_comb begin
        ena_d    = ena_q;
        force_d  = force_q;
        fast_d   = fast_q;
        defv_d   = defv_q;
        wmask_d  = wmask_q;
        wstat_d  = wstat_q;
        prdata_d = prdata_q;
        if (wr_acc) begin
            case (apb_req.paddr)
                DCV_OFF_ENA:   ena_d   = apb_req.pwdata;
                DCV_OFF_FORCE: force_d = apb_req.pwdata;
                DCV_OFF_FAST:  fast_d  = apb_req.pwdata;
                DCV_OFF_DEFV:  defv_d  = apb_req.pwdata;
                DCV_OFF_WMASK: wmask_d = apb_req.pwdata;
                DCV_OFF_WSTAT: wstat_d = wstat_q & ~apb_req.pwdata;
                default:       ena_d   = ena_q;
            endcase
        end
        // a wake level in the clear cycle survives: set wins
        wstat_d = wstat_d | wake_lvl;
        if (setup) begin
            prdata_d = (addr_ok && !apb_req.pwrite) ? rd_word : DCV_RST_WORD;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ena_q     <= DCV_RST_WORD;
            force_q   <= DCV_RST_WORD;
            fast_q    <= DCV_RST_WORD;
            defv_q    <= DCV_RST_WORD;
            wmask_q   <= DCV_RST_WORD;
            wstat_q   <= DCV_RST_WORD;
            prdata_q  <= DCV_RST_WORD;
            fastreq_q <= 1'b0;
            normreq_q <= 1'b0;
        end else begin
            ena_q     <= ena_d;
            force_q   <= force_d;
            fast_q    <= fast_d;
            defv_q    <= defv_d;
            wmask_q   <= wmask_d;
            wstat_q   <= wstat_d;
            prdata_q  <= prdata_d;
            fastreq_q <= fastreq_d;
            normreq_q <= normreq_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign apb_rsp.prdata  = prdata_q;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access & ~addr_ok;

    assign fast_cpu_request   = fastreq_q;
    assign normal_cpu_request = normreq_q;

endmodule

// ==== dcv_irq_checker.sv ====
// Purpose: port checker of dcv_irq_top
// Assumes: zero-wait apb slave
// Notes:   bound at the foot
`timescale 1ns/1ps
module dcv_irq_checker
    import dcv_pkg::*;
(
    // clock and reset
    input wire logic            ref_clk,
    input wire logic            arst_n,
    // bus and sources
    input wire dcv_apb_req_type apb_req,
    input wire dcv_apb_rsp_type apb_rsp,
    input wire logic [26:0]     periph_req,
    input wire logic [3:0]      wake_aux_req,
    input wire logic [29:0]     ext_wake_line,
    input wire logic            rtc_irq,
    input wire logic            usb_resume,
    // requests
    input wire logic            fast_cpu_request,
    input wire logic            normal_cpu_request,
    input wire logic            wake_irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic acc;
    logic why;
    assign acc = apb_req.psel && apb_req.penable;
    // a rise needs a live source, a wake bit or a register write
    // a register write lands one edge before the request output moves
    assign why = (|periph_req) || (|wake_aux_req) || wake_irq || (acc && apb_req.pwrite);
    sequence raw_setup;
        apb_req.psel && !apb_req.penable && apb_req.paddr == DCV_OFF_RAW
            && $stable(periph_req) && $stable(wake_aux_req);
    endsequence
    a_ready_high: assert property (apb_rsp.pready) else $error("pready low");
    a_err_access: assert property (apb_rsp.pslverr |-> acc) else $error("stray pslverr");
    a_err_zero:
        assert property (acc && apb_rsp.pslverr && !apb_req.pwrite |-> apb_rsp.prdata == '0)
        else $error("refused read not zero");
    a_unmapped_err:
        assert property (acc && apb_req.paddr == 12'h030 |-> apb_rsp.pslverr)
        else $error("unmapped read accepted");
    a_vect_ok:
        assert property (acc && apb_req.paddr == DCV_OFF_VECT |-> !apb_rsp.pslverr)
        else $error("vector read refused");
    a_raw_capture:
        assert property (raw_setup ##1 ($stable(periph_req) && $stable(wake_aux_req))
            |-> apb_rsp.prdata[24:0] == periph_req[24:0]
            && apb_rsp.prdata[31:26] == {periph_req[26:25], wake_aux_req})
        else $error("raw word wrong");
    a_normal_why:
        assert property ($rose(normal_cpu_request) |-> wake_irq || $past(why) || $past(why, 2))
        else $error("normal rose without cause");
    a_fast_why:
        assert property ($rose(fast_cpu_request) |-> $past(why) || $past(why, 2))
        else $error("fast without cause");
endmodule

bind dcv_irq_top dcv_irq_checker u_chk (
    .ref_clk, .arst_n, .apb_req, .apb_rsp, .periph_req, .wake_aux_req, .ext_wake_line,
    .rtc_irq, .usb_resume, .fast_cpu_request, .normal_cpu_request, .wake_irq
);

// ==== dcv_cpu_model.sv ====
// Purpose: processor side taking fast and normal requests
// Assumes: requests are levels on ref_clk
// Notes:   only records that each handler was entered
`timescale 1ns/1ps
module dcv_cpu_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // requests and entries
    input wire logic fast_req,
    input wire logic normal_req,
    output logic     seen_fast,
    output logic     seen_normal
);
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            seen_fast   <= 1'b0;
            seen_normal <= 1'b0;
        end else begin
            seen_fast   <= seen_fast | fast_req;
            // normal entry, source read by bench
            seen_normal <= seen_normal | normal_req;
        end
    end
endmodule

// ==== dual_chained_vectored_irq_unit_tb_top.sv ====
// Purpose: self-checking bench of dcv_irq_top
// Assumes: zero-wait apb, identity map at reset
// Notes:   winner recomputed from bench-held register state
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end
module dual_chained_vectored_irq_unit_tb_top
    import dcv_pkg::*;
;
    logic            ref_clk = 1'b0, arst_n = 1'b0, rtc_irq = 1'b0, usb_resume = 1'b0, wk = 1'b0;
    logic            fast_cpu_request, normal_cpu_request, wake_irq, seen_fast, seen_normal;
    logic [26:0]     periph_req = '0;
    logic [3:0]      wake_aux_req = '0;
    logic [29:0]     ext_wake_line = '0;
    logic [31:0]     seed = 32'h0000_67e3, ena, fst, frc, raw, pend, r;
    logic [3:0]      mp [32];
    dcv_apb_req_type apb_req = '0;
    dcv_apb_rsp_type apb_rsp;
    int              num_errors = 0, comparisons = 0, w, s;
    dcv_irq_top uut (
        .ref_clk, .arst_n, .apb_req, .apb_rsp, .periph_req, .wake_aux_req, .ext_wake_line,
        .rtc_irq, .usb_resume, .fast_cpu_request, .normal_cpu_request, .wake_irq
    );
    dcv_cpu_model cpu (
        .ref_clk, .arst_n, .fast_req(fast_cpu_request), .normal_req(normal_cpu_request),
        .seen_fast, .seen_normal
    );
    initial forever #20 ref_clk = ~ref_clk;
    initial begin
        #(40 * 20000);
        num_errors++;
        stop_test();
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] vx(int n);
        return (n < 32) ? 32'h1000_0000 + 32'(n * 16) : 32'hdead_0000;
    endfunction
    task automatic stop_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        do @(posedge ref_clk); while (apb_rsp.pready !== 1'b1);
        r = apb_rsp.prdata;
        apb_req <= '0;
        @(posedge ref_clk);
    endtask
    task automatic check_all();
        int m;
        raw = {periph_req[26:25], wake_aux_req, wk, periph_req[24:0]};
        w = 32;
        for (int c = 31; c >= 0; c--) begin
            m = (c & 16) | int'(mp[c]);
            pend[c] = (raw[m] & ena[m] & ~fst[m]) | frc[c];
            if (pend[c]) begin
                w = c;
                s = m;
            end
        end
        @(negedge ref_clk);
        `CHK(normal_cpu_request, |pend)
        `CHK(fast_cpu_request, |(raw & ena & fst))
        `CHK(wake_irq, wk)
        @(posedge ref_clk);
        apb(1'b0, DCV_OFF_RAW, '0);
        `CHK(r, raw)
        apb(1'b0, DCV_OFF_VECT, '0);
        `CHK(r, vx(w))
        apb(1'b0, DCV_OFF_SRCID, '0);
        `CHK(r[5], w < 32)
        if (w < 32) `CHK(r[4:0], 5'(s))
        apb(1'b0, DCV_OFF_REQST, '0);
        `CHK(r[1:0], {|(raw & ena & fst), |pend})
    endtask
    initial begin
        for (int c = 0; c < 32; c++) mp[c] = 4'(c & 15);
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, 12'h20C, '0);
        `CHK(r, 32'h0000_0003)
        apb(1'b0, 12'h030, '0);
        `CHK(r, 32'h0000_0000)
        apb(1'b1, DCV_OFF_DEFV, vx(32));
        for (int n = 0; n < 32; n++) apb(1'b1, 12'h100 + 12'(n * 4), vx(n));
        for (int k = 0; k < 40; k++) begin
            ena = xs();
            fst = (k % 4 == 0) ? xs() : '0;
            // odd rounds keep a forced lowest channel
            frc = (k % 2 == 1) ? 32'h8000_0000 : xs();
            s = int'(xs() & 32'h0000_001f);
            mp[s] = 4'(xs());
            apb(1'b1, 12'h200 + 12'(s * 4), 32'(mp[s]));
            apb(1'b1, DCV_OFF_ENA, ena);
            apb(1'b1, DCV_OFF_FAST, fst);
            apb(1'b1, DCV_OFF_FORCE, frc);
            periph_req <= 27'(xs());
            wake_aux_req <= 4'(xs());
            repeat (3) @(posedge ref_clk);
            check_all();
        end
        {ena, fst, frc} = {32'hffff_ffff, 64'h0};
        mp[25] = 4'h9;
        periph_req <= '0;
        wake_aux_req <= '0;
        apb(1'b1, 12'h264, 32'h0000_0009);
        apb(1'b1, DCV_OFF_ENA, ena);
        apb(1'b1, DCV_OFF_FAST, fst);
        apb(1'b1, DCV_OFF_FORCE, frc);
        apb(1'b1, DCV_OFF_WMASK, 32'h8000_0001);
        for (int p = 0; p < 4; p++) begin
            ext_wake_line <= 30'(p == 0);
            rtc_irq <= (p == 1);
            usb_resume <= (p == 2);
            repeat (8) @(posedge ref_clk);
            if (p % 2 == 1) apb(1'b1, DCV_OFF_WSTAT, 32'hffff_ffff);
            wk = (p % 2 == 0);
            check_all();
            apb(1'b0, DCV_OFF_WSTAT, '0);
            // rtc bit stays sticky through round 2, cleared only in round 3
            `CHK(r, {p == 1 || p == 2, 29'h0, p == 0} | {p == 2, 31'h0})
        end
        `CHK({seen_fast, seen_normal}, 2'b11)
        stop_test();
    end
endmodule
